// ==== logic/iasm_arbiter.sv ====
// Interrupt acceptance, arbitration and dispatch for the CPU core.
// Assumes synchronous request pulses from peripherals and a core that
// performs stacking, bank switching or macro transfer on each dispatch.
`timescale 1ns/1ps

// What this block does
// - Default rank only breaks ties among equal programmed levels.
// - Watch interval: rank 15, vector 0024H, control word 0FE24H.
// - 16-bit timer matches: ranks 16/17, vectors 0026H/0028H.
// - 8-bit timers 1 and 2: ranks 18/19, vectors 002AH/002CH.
// - A/D done: rank 20, vector 002EH, control word 0FE2EH.
// - 8-bit timers 5 to 8: ranks 21-24, vectors 0030H-0036H.
// - Watch overflow: rank 25, vector 0038H, control word 0FE38H.
// - Key-return falling edge: rank 26, vector 003AH, word 0FE3AH.
// - Plain break vectors; bank-switch break does a context switch.
// - Software interrupts ignore global enable and priority levels.
// - Illegal operand in standby, watchdog or placement writes traps.
// - Operand traps ignore global enable and priority levels.
// - Non-maskable request from NMI pin or watchdog overflow.
// - NMI taken always, except under same or higher NMI handler.
// - NMI outranks everything and skips priority levels.
// - Maskable request blocked by own mask and by global enable.
// - Four programmable levels arbitrate and nest maskable requests.
// - Macro service ignores global enable and priority levels.
// - Vectored accept pushes PC and status word, then branches.
// - Macro service suspends the core, no PC or status save.
// - Context switch selects bank, branches, saves PC and status.
// - Each source has flag, mask, macro enable, level, switch enable.
// - Mode bit decides whether level 3 requests may nest.
// - NMI pin vectors to 0002H, watchdog NMI to 0004H.
module iasm_arbiter (
  input  wire  logic                clk,                     // 40 MHz clock
  input  wire  logic                rst_n,                   // Sync reset
  input  wire  logic [7:0]          addr,                    // Register address
  input  wire  logic [7:0]          wdata,                   // Write data
  input  wire  logic                wr_en,                   // Write strobe
  input  wire  logic                rd_en,                   // Read strobe
  output var   logic [7:0]          rdata,                   // Read data, next cycle
  input  wire  logic                watch_interval_req,      // Rank 15 pulse
  input  wire  logic                timer16_match_a_req,     // Rank 16 pulse
  input  wire  logic                timer16_match_b_req,     // Rank 17 pulse
  input  wire  logic                timer8_unit1_match_req,  // Rank 18 pulse
  input  wire  logic                timer8_unit2_match_req,  // Rank 19 pulse
  input  wire  logic                adc_done_req,            // Rank 20 pulse
  input  wire  logic                timer8_unit5_match_req,  // Rank 21 pulse
  input  wire  logic                timer8_unit6_match_req,  // Rank 22 pulse
  input  wire  logic                timer8_unit7_match_req,  // Rank 23 pulse
  input  wire  logic                timer8_unit8_match_req,  // Rank 24 pulse
  input  wire  logic                watch_overflow_req,      // Rank 25 pulse
  input  wire  logic [7:0]          key_return_in,           // Port 8 key inputs
  input  wire  logic                global_irq_enable,       // Status word enable
  input  wire  logic                soft_vector_instr,       // Plain break pulse
  input  wire  logic                soft_bank_switch_instr,  // Bank break pulse
  input  wire  logic [2:0]          soft_bank_sel,           // Bank of bank break
  input  wire  logic                operand_err,             // Illegal operand pulse
  input  wire  logic                nmi_pin,                 // NMI pin level
  input  wire  logic                wdt_overflow,            // Watchdog NMI pulse
  input  wire  logic                svc_return,              // Handler return pulse
  output var   logic                ack_valid,               // Dispatch pulse
  output var   iasm_pkg::iasm_ack_t ack                      // Dispatch detail
);
  import iasm_pkg::*;

  // Registered state
  iasm_ctl_t        ctl_r    [IASM_NSRC];
  iasm_ctl_t        ctl_nxt  [IASM_NSRC];
  logic             nest_r,  nest_nxt;
  logic [2:0]       bank_r,  bank_nxt;
  logic [3:0]       isp_r,   isp_nxt;
  logic             nmi_isr_r,  nmi_isr_nxt;
  logic             wdt_isr_r,  wdt_isr_nxt;
  logic             nmi_pnd_r,  nmi_pnd_nxt;
  logic             wdt_pnd_r,  wdt_pnd_nxt;
  logic             trap_pnd_r, trap_pnd_nxt;
  logic             brk_pnd_r,  brk_pnd_nxt;
  logic             bcs_pnd_r,  bcs_pnd_nxt;
  logic [2:0]       bcs_bank_r, bcs_bank_nxt;
  logic             nmi_pin_r;
  logic [7:0]       key_r;
  logic [7:0]       rdata_nxt;
  logic             ack_valid_nxt;
  iasm_ack_t        ack_nxt;

  // Arbitration results
  logic [IASM_NSRC-1:0] hw_set;
  logic             key_fall;
  logic             nmi_rise;
  logic             mk_hit;
  logic             mk_macro;
  logic [3:0]       mk_idx;
  logic             ctl_wr;
  logic [3:0]       ctl_idx;
  logic             mk_elig;
  logic             mk_mac;

  // True when a level may be accepted over what is in service
  function automatic logic lvl_ok(input logic [1:0] lv, input logic [3:0] isp,
                                  input logic nest);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (isp[i] && ok)
      begin
        // Only the innermost running level is compared
        ok = (lv < 2'(i)) || (nest && lv == IASM_LVL_LOW && i == 3);
        break;
      end
    end
    return ok;
  endfunction : lvl_ok

  // Lowest set bit is the level currently running
  function automatic logic [3:0] pop_lvl(input logic [3:0] isp);
    logic [3:0] res;
    res = isp;
    for (int i = 0; i < 4; i++)
    begin
      if (isp[i])
      begin
        // Innermost level is the lowest set bit
        res[i] = 1'b0;
        break;
      end
    end
    return res;
  endfunction : pop_lvl

  // Source order fixes the default ranks
  // rank 15 source
  // key-return falling edge raises rank 26
  // Any one of the eight lines falling is enough
  assign key_fall = |(key_r & ~key_return_in);
  assign nmi_rise = nmi_pin & ~nmi_pin_r;
  // 16-bit matches at ranks 16, 17
  // 8-bit units 1, 2 at 18, 19
  // 8-bit units 5 to 8 at 21-24
  assign hw_set = {key_fall, watch_overflow_req, timer8_unit8_match_req,
                   timer8_unit7_match_req, timer8_unit6_match_req,
                   timer8_unit5_match_req, adc_done_req, timer8_unit2_match_req,
                   timer8_unit1_match_req, timer16_match_b_req,
                   timer16_match_a_req, watch_interval_req};
  assign ctl_wr  = wr_en && addr < (IASM_CTL_BASE + 8'(IASM_NSRC));
  assign ctl_idx = 4'(addr - IASM_CTL_BASE);

  // Pick the best maskable candidate
  always_comb
  begin
    mk_hit   = 1'b0;
    mk_macro = 1'b0;
    mk_idx   = 4'h0;
    mk_elig  = 1'b0;
    mk_mac   = 1'b0;
    // Macro and vectored candidates compete on level, then rank
    for (int i = 0; i < IASM_NSRC; i++)
    begin
      // own mask blocks every kind of service
      // macro service skips enable and level checks
      mk_mac  = ctl_r[i].msen;
      mk_elig = ctl_r[i].flag && !ctl_r[i].mask &&
                (mk_mac || (global_irq_enable && lvl_ok(ctl_r[i].pri, isp_r, nest_r)));
      // equal levels keep the earlier, higher-ranked source
      if (mk_elig && (!mk_hit || ctl_r[i].pri < ctl_r[mk_idx].pri))
      begin
        mk_hit   = 1'b1;
        mk_macro = mk_mac;
        mk_idx   = 4'(i);
      end
    end
  end

  // Next state: pending events, flags, in-service levels, dispatch
  always_comb
  begin
    ctl_nxt       = ctl_r;
    nest_nxt      = nest_r;
    bank_nxt      = bank_r;
    isp_nxt       = isp_r;
    nmi_isr_nxt   = nmi_isr_r;
    wdt_isr_nxt   = wdt_isr_r;
    bcs_bank_nxt  = bcs_bank_r;
    // Dispatch detail stays zero unless a grant is made
    ack_valid_nxt = 1'b0;
    ack_nxt       = '0;
    // Handler return ends pin NMI, else watchdog NMI, else the innermost level
    // Limitation: a level nested over itself is recorded once, so the
    // first return of such a pair already frees that level
    if (svc_return)
    begin
      if (nmi_isr_r)
        nmi_isr_nxt = 1'b0;
      else if (wdt_isr_r)
        wdt_isr_nxt = 1'b0;
      else
        isp_nxt = pop_lvl(isp_r);
    end
    // Software writes; a hardware set in the same cycle wins below
    // per-source control register
    if (ctl_wr)
      ctl_nxt[ctl_idx] = iasm_ctl_t'(wdata[5:0]);
    if (wr_en && addr == IASM_MODE_ADR)
      nest_nxt = wdata[0];
    // Bank used by maskable context switches
    if (wr_en && addr == IASM_BANK_ADR)
      bank_nxt = wdata[2:0];
    // Pending instruction and NMI events survive a busy cycle
    // pin edge or watchdog overflow
    nmi_pnd_nxt  = nmi_pnd_r | nmi_rise;
    wdt_pnd_nxt  = wdt_pnd_r | wdt_overflow;
    trap_pnd_nxt = trap_pnd_r | operand_err;
    brk_pnd_nxt  = brk_pnd_r | soft_vector_instr;
    bcs_pnd_nxt  = bcs_pnd_r | soft_bank_switch_instr;
    if (soft_bank_switch_instr)
      bcs_bank_nxt = soft_bank_sel;
    // NMI first, level mechanism not consulted
    // Pin NMI ranks above watchdog NMI
    // blocked only by same or higher NMI handler
    if (nmi_pnd_r && !nmi_isr_r)
    begin
      nmi_pnd_nxt     = nmi_rise;
      nmi_isr_nxt     = 1'b1;
      ack_valid_nxt   = 1'b1;
      ack_nxt.nmi     = 1'b1;
      ack_nxt.push_ctx = 1'b1;
      ack_nxt.vector  = IASM_VEC_NMI;
    end
    else if (wdt_pnd_r && !wdt_isr_r && !nmi_isr_r)
    begin
      wdt_pnd_nxt     = wdt_overflow;
      wdt_isr_nxt     = 1'b1;
      ack_valid_nxt   = 1'b1;
      ack_nxt.nmi     = 1'b1;
      ack_nxt.push_ctx = 1'b1;
      ack_nxt.vector  = IASM_VEC_WDT;
    end
    // Trap and breaks come from instructions, never enter in-service
    // trap ignores enable and levels
    else if (trap_pnd_r)
    begin
      trap_pnd_nxt    = operand_err;
      ack_valid_nxt   = 1'b1;
      ack_nxt.push_ctx = 1'b1;
      ack_nxt.vector  = IASM_VEC_TRAP;
    end
    // software breaks ignore enable and levels
    else if (brk_pnd_r)
    begin
      brk_pnd_nxt     = soft_vector_instr;
      ack_valid_nxt   = 1'b1;
      ack_nxt.push_ctx = 1'b1;
      ack_nxt.vector  = IASM_VEC_BRK;
    end
    else if (bcs_pnd_r)
    begin
      bcs_pnd_nxt     = soft_bank_switch_instr;
      ack_valid_nxt   = 1'b1;
      ack_nxt.mode    = IASM_CTXSW;
      ack_nxt.bank    = bcs_bank_r;
    end
    else if (mk_hit)
    begin
      // acceptance clears the request flag; a software set of
      // the same flag in this cycle wins so that request is not lost
      if (!(ctl_wr && ctl_idx == mk_idx && wdata[IASM_F_FLAG]))
        ctl_nxt[mk_idx].flag = 1'b0;
      ack_valid_nxt   = 1'b1;
      ack_nxt.rank    = 5'(IASM_RANK_BASE) + 5'(mk_idx);
      // vector and control word by rank
      ack_nxt.vector  = IASM_VEC_TBL[mk_idx];
      ack_nxt.mcw     = IASM_MCW_TBL[mk_idx];
      if (mk_macro)
        ack_nxt.mode  = IASM_MACRO;
      else
      begin
        // level recorded for later nesting checks
        isp_nxt[ctl_r[mk_idx].pri] = 1'b1;
        if (ctl_r[mk_idx].cse)
        begin
          // bank switch saves PC and status in the bank
          ack_nxt.mode = IASM_CTXSW;
          ack_nxt.bank = bank_r;
        end
        else
          // vectored push of PC and status word
          ack_nxt.push_ctx = 1'b1;
      end
    end
    // Hardware set wins over software clear or acceptance
    for (int i = 0; i < IASM_NSRC; i++)
    begin
      if (hw_set[i])
        ctl_nxt[i].flag = 1'b1;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_comb
  begin
    // Unmapped addresses and idle cycles read as zero
    rdata_nxt = 8'h00;
    if (rd_en)
    begin
      if (addr < (IASM_CTL_BASE + 8'(IASM_NSRC)))
        rdata_nxt = {2'h0, ctl_r[ctl_idx]};
      else if (addr == IASM_MODE_ADR)
        rdata_nxt = {7'h00, nest_r};
      else if (addr == IASM_ISP_ADR)
        rdata_nxt = {2'h0, wdt_isr_r, nmi_isr_r, isp_r};
      else if (addr == IASM_BANK_ADR)
        rdata_nxt = {5'h00, bank_r};
    end
  end

  // Registers; key lines idle high so reset sees no edge
  // Synchronous reset only; every register runs on every edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < IASM_NSRC; i++)
        ctl_r[i] <= iasm_ctl_t'(IASM_CTL_RST);
      nest_r     <= IASM_NEST_RST;
      bank_r     <= IASM_BANK_RST;
      isp_r      <= 4'h0;
      nmi_isr_r  <= 1'b0;
      wdt_isr_r  <= 1'b0;
      nmi_pnd_r  <= 1'b0;
      wdt_pnd_r  <= 1'b0;
      trap_pnd_r <= 1'b0;
      brk_pnd_r  <= 1'b0;
      bcs_pnd_r  <= 1'b0;
      bcs_bank_r <= 3'h0;
      nmi_pin_r  <= 1'b0;
      key_r      <= 8'hFF;
      rdata      <= 8'h00;
      ack_valid  <= 1'b0;
      ack        <= '0;
    end
    else
    begin
      ctl_r      <= ctl_nxt;
      nest_r     <= nest_nxt;
      bank_r     <= bank_nxt;
      isp_r      <= isp_nxt;
      nmi_isr_r  <= nmi_isr_nxt;
      wdt_isr_r  <= wdt_isr_nxt;
      nmi_pnd_r  <= nmi_pnd_nxt;
      wdt_pnd_r  <= wdt_pnd_nxt;
      trap_pnd_r <= trap_pnd_nxt;
      brk_pnd_r  <= brk_pnd_nxt;
      bcs_pnd_r  <= bcs_pnd_nxt;
      bcs_bank_r <= bcs_bank_nxt;
      nmi_pin_r  <= nmi_pin;
      key_r      <= key_return_in;
      rdata      <= rdata_nxt;
      ack_valid  <= ack_valid_nxt;
      ack        <= ack_nxt;
    end
  end

endmodule : iasm_arbiter

// ==== logic/iasm_pkg.sv ====
// Constants, types and tables for the interrupt arbiter.
// Assumes one 40 MHz clock and the CPU core handling the actual stacking.
package iasm_pkg;

  // Maskable sources, index 0 is the highest default rank
  localparam int          IASM_NSRC      = 12;
  localparam int          IASM_RANK_BASE = 15;
  localparam logic [1:0]  IASM_LVL_LOW   = 2'h3;

  // Register map on the plain port
  localparam logic [7:0]  IASM_CTL_BASE  = 8'h00;
  localparam logic [7:0]  IASM_MODE_ADR  = 8'h10;
  localparam logic [7:0]  IASM_ISP_ADR   = 8'h11;
  localparam logic [7:0]  IASM_BANK_ADR  = 8'h12;

  // Field positions of a control register
  localparam int          IASM_F_FLAG    = 0;
  localparam int          IASM_F_MASK    = 1;
  localparam int          IASM_F_MSEN    = 2;
  localparam int          IASM_F_PRI     = 3;
  localparam int          IASM_F_CSE     = 5;

  // Values after reset: masked, lowest level, nothing pending
  localparam logic [5:0]  IASM_CTL_RST   = 6'h1A;
  localparam logic        IASM_NEST_RST  = 1'h0;
  localparam logic [2:0]  IASM_BANK_RST  = 3'h0;

  // Fixed vectors of the non-maskable and software sources
  localparam logic [15:0] IASM_VEC_NMI   = 16'h0002;
  localparam logic [15:0] IASM_VEC_WDT   = 16'h0004;
  localparam logic [15:0] IASM_VEC_TRAP  = 16'h003C;
  localparam logic [15:0] IASM_VEC_BRK   = 16'h003E;

  // Vector and macro-service control word per maskable source
  localparam logic [15:0] IASM_VEC_TBL [IASM_NSRC] = '{
    16'h0024, 16'h0026, 16'h0028, 16'h002A, 16'h002C, 16'h002E,
    16'h0030, 16'h0032, 16'h0034, 16'h0036, 16'h0038, 16'h003A};
  localparam logic [15:0] IASM_MCW_TBL [IASM_NSRC] = '{
    16'hFE24, 16'hFE26, 16'hFE28, 16'hFE2A, 16'hFE2C, 16'hFE2E,
    16'hFE30, 16'hFE32, 16'hFE34, 16'hFE36, 16'hFE38, 16'hFE3A};

  typedef enum logic [1:0] {
    IASM_VECTORED = 2'b00,
    IASM_MACRO    = 2'b01,
    IASM_CTXSW    = 2'b10
  } iasm_mode_t;

  typedef struct packed {
    logic       cse;
    logic [1:0] pri;
    logic       msen;
    logic       mask;
    logic       flag;
  } iasm_ctl_t;

  // One dispatch to the core
  typedef struct packed {
    iasm_mode_t mode;
    logic [15:0] vector;
    logic [15:0] mcw;
    logic [4:0]  rank;
    logic [2:0]  bank;
    logic        push_ctx;
    logic        nmi;
  } iasm_ack_t;

endpackage : iasm_pkg

// ==== verif/iasm_arbiter_monitor.sv ====
// Checker of dispatch detail and register read data.
// Assumes binding onto iasm_arbiter and its ports only.
`timescale 1ns/1ps
module iasm_arbiter_monitor (
  input wire logic                clk,               // Clock
  input wire logic                rst_n,             // Reset
  input wire logic                rd_en,             // Read strobe
  input wire logic [7:0]          rdata,             // Read data
  input wire logic                global_irq_enable, // Enable
  input wire logic                operand_err,       // Trap event
  input wire logic                ack_valid,         // Dispatch
  input wire iasm_pkg::iasm_ack_t ack                // Detail
);
  import iasm_pkg::*;
  // One domain, so one clock and one disable
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_ACK_IDLE: assert property (!ack_valid |-> ack == '0)
    else $error("dispatch detail not zero while idle");
  AST_VEC_PUSH: assert property (ack_valid && ack.mode == IASM_VECTORED |-> ack.push_ctx)
    else $error("vectored dispatch without push");
  AST_NMI_VEC: assert property (ack_valid && ack.nmi |-> ack.rank == 5'h00
    && (ack.vector == IASM_VEC_NMI || ack.vector == IASM_VEC_WDT))
    else $error("nmi vector wrong");
  AST_MACRO: assert property (ack_valid && ack.mode == IASM_MACRO
    |-> !ack.push_ctx && !ack.nmi && ack.rank != 5'h00)
    else $error("macro dispatch saves context");
  AST_VEC_MAP: assert property (ack_valid && ack.rank != 5'h00
    |-> ack.vector == 16'h0024 + {10'h000, ack.rank - 5'h0F, 1'b0})
    else $error("maskable vector does not follow rank");
  AST_MCW_MAP: assert property (ack_valid && ack.rank != 5'h00
    |-> ack.mcw == {8'hFE, ack.vector[7:0]})
    else $error("control word does not follow vector");
  AST_IE_GATE: assert property (ack_valid && ack.rank != 5'h00 && ack.mode != IASM_MACRO
    |-> $past(global_irq_enable))
    else $error("maskable taken while disabled");
  AST_TRAP_LAT: assert property (operand_err
    |-> ##[1:4] (ack_valid && ack.vector == IASM_VEC_TRAP))
    else $error("trap not dispatched in time");
  AST_RD_IDLE: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_n |=> !ack_valid && rdata == 8'h00)
    else $error("outputs active after reset");
endmodule : iasm_arbiter_monitor

bind iasm_arbiter iasm_arbiter_monitor iasm_arbiter_monitor_inst (
  .clk, .rst_n, .rd_en, .rdata, .global_irq_enable, .operand_err, .ack_valid, .ack);

// ==== verif/iasm_arbiter_test.sv ====
// Self-checking bench for the interrupt arbiter.
// Assumes the core model and the bound checker beside the design.
`timescale 1ns/1ps
module iasm_arbiter_test;
  import iasm_pkg::*;
  logic clk, rst_n, wr_en, rd_en, global_irq_enable, nmi_pin, wdt_overflow;
  logic soft_vector_instr, soft_bank_switch_instr, operand_err, svc_return;
  logic ret_now, ack_valid;
  logic [7:0]  addr, wdata, rdata, key_return_in;
  logic [10:0] req;
  logic [2:0]  soft_bank_sel;
  iasm_ack_t   ack;
  int          error_cnt, checks_done, i;

  iasm_arbiter iasm_arbiter_inst (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .watch_interval_req(req[0]), .timer16_match_a_req(req[1]),
    .timer16_match_b_req(req[2]), .timer8_unit1_match_req(req[3]),
    .timer8_unit2_match_req(req[4]), .adc_done_req(req[5]),
    .timer8_unit5_match_req(req[6]), .timer8_unit6_match_req(req[7]),
    .timer8_unit7_match_req(req[8]), .timer8_unit8_match_req(req[9]),
    .watch_overflow_req(req[10]), .key_return_in, .global_irq_enable,
    .soft_vector_instr, .soft_bank_switch_instr, .soft_bank_sel, .operand_err,
    .nmi_pin, .wdt_overflow, .svc_return, .ack_valid, .ack);
  iasm_core_model iasm_core_model_inst (.clk, .rst_n, .ack_valid, .ack, .ret_now,
    .svc_return);

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, e});
  endtask : rd

  // One-cycle events; bit 11 of m is a key falling edge
  task automatic pulse(input logic [11:0] m, input logic [4:0] e);
    @(posedge clk);
    req <= m[10:0];
    key_return_in <= m[11] ? 8'hF7 : 8'hFF;
    {nmi_pin, wdt_overflow, operand_err, soft_bank_switch_instr, soft_vector_instr} <= e;
    @(posedge clk);
    req <= '0;
    key_return_in <= 8'hFF;
    {nmi_pin, wdt_overflow, operand_err, soft_bank_switch_instr, soft_vector_instr} <= '0;
  endtask : pulse

  // Bounded wait for a dispatch, then compare mode/vector/rank/push/nmi
  task automatic got(input logic [24:0] e, input logic [24:0] k = 25'h1FFFFFF);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (ack_valid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (ack_valid !== 1'b1)
    begin
      error_cnt++;
      close_out();
    end
    else
      chk({7'h0, {ack.mode, ack.vector, ack.rank, ack.push_ctx, ack.nmi} & k}, {7'h0, e & k});
  endtask : got

  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1;
      seen = seen | ack_valid;
    end
    chk({31'h0, seen}, 32'h0);
  endtask : quiet

  task automatic ret();
    @(posedge clk);
    ret_now <= 1'b1;
    @(posedge clk);
    ret_now <= 1'b0;
  endtask : ret

  // Main sequence
  initial
  begin
    {addr, wdata, wr_en, rd_en, req, global_irq_enable, ret_now} = '0;
    {nmi_pin, wdt_overflow, operand_err, soft_bank_switch_instr, soft_vector_instr} = '0;
    key_return_in = 8'hFF;
    soft_bank_sel = 3'h5;
    rst_n = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++)
      rd(8'(i), 8'h1A);
    rd(IASM_MODE_ADR, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    // Every maskable source, vectored at level 0
    @(posedge clk) global_irq_enable <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      wr(8'(i), 8'h00);
      pulse(12'h001 << i, 5'h00);
      got({IASM_VECTORED, 16'h0024 + 16'(2 * i), 5'(15 + i), 2'b10});
      rd(8'(i), 8'h00);
      rd(IASM_ISP_ADR, 8'h01);
      ret();
      rd(IASM_ISP_ADR, 8'h00);
    end
    // Own mask, then global enable, hold a request back
    wr(8'h05, 8'h02);
    pulse(12'h020, 5'h00);
    quiet();
    rd(8'h05, 8'h03);
    @(posedge clk) global_irq_enable <= 1'b0;
    wr(8'h05, 8'h01);
    quiet();
    @(posedge clk) global_irq_enable <= 1'b1;
    got({IASM_VECTORED, 16'h002E, 5'h14, 2'b10});
    ret();
    // Macro service at level 3 with enable off
    global_irq_enable <= 1'b0;
    wr(8'h0A, 8'h1C);
    pulse(12'h400, 5'h00);
    got({IASM_MACRO, 16'h0038, 5'h19, 2'b00});
    chk({16'h0, ack.mcw}, 32'h0000FE38);
    rd(IASM_ISP_ADR, 8'h00);
    // Level beats rank; ties by rank; no equal-level nesting
    @(posedge clk) global_irq_enable <= 1'b1;
    wr(8'h01, 8'h08);
    wr(8'h02, 8'h08);
    pulse(12'h00E, 5'h00);
    got({IASM_VECTORED, 16'h002A, 5'h12, 2'b10});
    quiet();
    ret();
    got({IASM_VECTORED, 16'h0026, 5'h10, 2'b10});
    quiet();
    ret();
    got({IASM_VECTORED, 16'h0028, 5'h11, 2'b10});
    ret();
    // Level 3 nests only once the mode bit allows it
    wr(8'h00, 8'h18);
    pulse(12'h001, 5'h00);
    got({IASM_VECTORED, 16'h0024, 5'h0F, 2'b10});
    pulse(12'h001, 5'h00);
    quiet();
    wr(IASM_MODE_ADR, 8'h01);
    got({IASM_VECTORED, 16'h0024, 5'h0F, 2'b10});
    ret();
    ret();
    wr(IASM_MODE_ADR, 8'h00);
    // Software, trap and NMI with enable off
    global_irq_enable <= 1'b0;
    pulse(12'h000, 5'h01);
    got({IASM_VECTORED, 16'h003E, 5'h00, 2'b10});
    pulse(12'h000, 5'h02);
    got({IASM_CTXSW, 23'h0}, {2'b11, 23'h0});
    chk({29'h0, ack.bank}, 32'h5);
    pulse(12'h000, 5'h04);
    got({IASM_VECTORED, 16'h003C, 5'h00, 2'b10});
    pulse(12'h000, 5'h10);
    got({IASM_VECTORED, 16'h0002, 5'h00, 2'b11});
    pulse(12'h000, 5'h18);
    quiet();
    ret();
    got({IASM_VECTORED, 16'h0002, 5'h00, 2'b11});
    ret();
    got({IASM_VECTORED, 16'h0004, 5'h00, 2'b11});
    ret();
    // Watchdog NMI wins over a maskable request in the same cycle
    global_irq_enable <= 1'b1;
    pulse(12'h020, 5'h08);
    got({IASM_VECTORED, 16'h0004, 5'h00, 2'b11});
    got({IASM_VECTORED, 16'h002E, 5'h14, 2'b10});
    ret();
    ret();
    // Maskable context switch uses the programmed bank
    wr(IASM_BANK_ADR, 8'h03);
    rd(IASM_BANK_ADR, 8'h03);
    wr(8'h04, 8'h20);
    pulse(12'h010, 5'h00);
    got({IASM_CTXSW, 16'h002C, 5'h13, 2'b00});
    chk({29'h0, ack.bank}, 32'h3);
    ret();
    rd(IASM_ISP_ADR, 8'h00);
    // Mid-run reset brings back the reset values of source 4 and the bank
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, 8'h1A);
    rd(IASM_BANK_ADR, 8'h00);
    close_out();
  end
endmodule : iasm_arbiter_test

// ==== verif/iasm_core_model.sv ====
// Behavioural core: counts open handlers, returns when asked.
// Assumes the bench requests each handler return by ret_now.
`timescale 1ns/1ps
module iasm_core_model (
  input  wire logic                clk,        // Clock
  input  wire logic                rst_n,      // Reset
  input  wire logic                ack_valid,  // Dispatch
  input  wire iasm_pkg::iasm_ack_t ack,        // Detail
  input  wire logic                ret_now,    // Return wanted
  output var  logic                svc_return  // Return pulse
);
  import iasm_pkg::*;
  int open_cnt;
  logic opens;
  // Break, trap and macro never return, else a level pops early
  assign opens = ack_valid && ack.mode != IASM_MACRO && (ack.nmi || ack.rank != 5'h00);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      open_cnt <= 0;
      svc_return <= 1'b0;
    end
    else
    begin
      svc_return <= ret_now && open_cnt != 0;
      open_cnt <= open_cnt + int'(opens) - int'(ret_now && open_cnt != 0);
    end
  end
endmodule : iasm_core_model
